// ### bench/utopia_cell_port_sva.sv
// Concurrent checks on the link pins and the attention flag of the UTOPIA cell port.
module utopia_cell_port_sva (
	// System side
	input wire logic clock,
	input wire logic reset,
	input wire logic side_select_pin,
	input wire logic cfg_write,
	input wire logic cfg_single_phy,
	input wire logic queue_add_set,
	input wire logic queue_add_attention,
	// Transmit link
	input wire logic tx_link_clock,
	input wire logic tx_data_bus_oe,
	input wire logic atm_tx_write_enable_n,
	input wire logic atm_tx_write_enable_oe,
	input wire logic phy_tx_read_enable_n,
	input wire logic atm_tx_full_n,
	input wire logic phy_tx_cell_avail_oe,
	input wire logic phy_tx_select_n,
	// Receive link
	input wire logic rx_link_clock,
	input wire logic atm_rx_read_enable_n,
	input wire logic phy_rx_cell_avail_oe,
	input wire logic phy_rx_select_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic single_q;
	// The role only counts once it has stood six link cycles, since it is synchronised into each domain.
	always_ff @(posedge clock)
		single_q <= reset ? 1'b0 : (cfg_write ? cfg_single_phy : single_q);
	wire atm_ok   = !side_select_pin && !reset;
	wire multi_ok = side_select_pin && !single_q && !reset;
	wire sphy_ok  = side_select_pin && single_q && !reset;

	a_attn_set_wins: assert property (@(posedge clock) disable iff (reset)
		queue_add_set |=> queue_add_attention) else $error("attention flag not set");
	a_atm_role_we: assert property (@(posedge tx_link_clock) disable iff (reset)
		atm_ok[*6] |-> atm_tx_write_enable_oe) else $error("write enable not driven in ATM role");
	a_phy_data_hiz: assert property (@(posedge tx_link_clock) disable iff (reset)
		(multi_ok || sphy_ok)[*6] ##0 tx_data_bus_oe |-> !$past(phy_tx_read_enable_n))
		else $error("PHY data driven without read enable");
	a_full_pause_two: assert property (@(posedge tx_link_clock) disable iff (reset)
		atm_ok[*6] ##0 !atm_tx_full_n |-> ##3 atm_tx_write_enable_n) else $error("byte sent after full");
	a_tx_cav_poll: assert property (@(posedge tx_link_clock) disable iff (reset)
		multi_ok[*6] |-> phy_tx_cell_avail_oe == !$past(phy_tx_select_n)) else $error("tx avail enable wrong");
	a_tx_cav_single: assert property (@(posedge tx_link_clock) disable iff (reset)
		sphy_ok[*6] |-> phy_tx_cell_avail_oe) else $error("tx avail not driven in single mode");
	a_rx_cav_poll: assert property (@(posedge rx_link_clock) disable iff (reset)
		multi_ok[*6] |-> phy_rx_cell_avail_oe == !$past(phy_rx_select_n)) else $error("rx avail enable wrong");
	a_rx_ren_reset: assert property (@(posedge clock) disable iff (reset)
		$fell(reset) |-> !atm_rx_read_enable_n) else $error("read enable idle in reset");
	a_cav_reset_hiz: assert property (@(posedge clock) disable iff (reset)
		$fell(reset) |-> !phy_rx_cell_avail_oe && !phy_tx_cell_avail_oe) else $error("avail driven in reset");

	c_atm_byte: cover property (@(posedge tx_link_clock) atm_ok && !atm_tx_write_enable_n);
	c_full_seen: cover property (@(posedge tx_link_clock) atm_ok && !atm_tx_full_n);
	c_phy_byte: cover property (@(posedge tx_link_clock) sphy_ok && tx_data_bus_oe);
endmodule // utopia_cell_port_sva

// ### bench/utopia_cell_port_tb.sv
// Self-checking bench of the UTOPIA cell port.
`include "utopia_defs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module utopia_cell_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, reset = 1, tx_link_clock = 0, rx_link_clock = 0, slow = 0, hold = 0;
	logic side_select_pin = 0, cfg_write = 0, cfg_single_phy = 0, queue_add_set = 0, queue_add_attention;
	logic [7:0] builder_data = 8'h00, proc_data, tx_data_bus, rx_data_bus;
	logic builder_soc = 0, builder_valid = 0, builder_ready, proc_soc, proc_valid, proc_ready = 0;
	logic tx_data_bus_oe, tx_cell_start, tx_cell_start_oe, atm_tx_write_enable_n, atm_tx_write_enable_oe;
	logic phy_tx_read_enable_n, atm_tx_full_n, phy_tx_cell_avail, phy_tx_cell_avail_oe, phy_tx_select_n;
	logic rx_cell_start, atm_rx_read_enable_n, atm_rx_read_enable_oe, phy_rx_write_enable_n, atm_rx_empty_n;
	logic phy_rx_cell_avail, phy_rx_cell_avail_oe, phy_rx_select_n;
	logic [8:0] txq[$], rxq[$], tw, rw;
	int seed = 32'h36e7cb29, failures = 0, cmp_count = 0;

	utopia_cell_port #(.AW(7)) dut (.*);
	utopia_partner p (.*);

	// Clocks: the link clocks are offset so no edge lines up with the system clock.
	initial forever #20 clock = ~clock;
	initial begin #3; forever #24 tx_link_clock = ~tx_link_clock; end
	initial begin #11; forever #24 rx_link_clock = ~rx_link_clock; end
	always @(posedge clock) proc_ready <= !hold && 1'($random(seed));

	// Monitors take the oldest note whenever a byte shows on the transmit link, or at the processor in the ATM role.
	always @(posedge tx_link_clock) if (!reset && (side_select_pin ? tx_data_bus_oe : !atm_tx_write_enable_n)) begin
		tw = txq.pop_front();
		`CHK("tx_byte", tw, {tx_cell_start, tx_data_bus})
	end
	always @(posedge clock) if (!side_select_pin && proc_valid === 1'b1 && proc_ready) begin
		rw = rxq.pop_front();
		`CHK("rx_word", rw, {proc_soc, proc_data})
	end

	task automatic do_reset(input logic side);
		reset <= 1'b1;
		side_select_pin <= side;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		repeat (10) @(posedge clock);
	endtask
	// Builder writes hold each byte until it is taken.
	task automatic send_cells(input int n);
		logic [8:0] w;
		for (int i = 0; i < n * `CELL_BYTES; i++) begin
			w = {i % `CELL_BYTES == 0, 8'($random(seed))};
			builder_data <= w[7:0];
			builder_soc <= w[8];
			builder_valid <= 1'b1;
			do @(posedge clock); while (builder_ready !== 1'b1);
			txq.push_back(w);
		end
		builder_valid <= 1'b0;
	endtask
	task automatic rx_send(input int n, input logic soc, input logic keep);
		logic [8:0] w;
		for (int i = 0; i < n; i++) begin
			w = {soc && i % `CELL_BYTES == 0, 8'($random(seed))};
			p.put(w);
			if (keep)
				rxq.push_back(w);
		end
	endtask
	task automatic wait_empty;
		for (int k = 0; k < 6000 && txq.size() + rxq.size() != 0; k++)
			@(posedge clock);
		`CHK("queues_left", 0, txq.size() + rxq.size())
	endtask
	task automatic conclude;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Main sequence: ATM traffic both ways, receive stall, then the PHY roles.
	initial begin
		do_reset(1'b0);
		for (int s = 0; s < 2; s++) begin
			slow <= (s == 1);
			rx_send(3, 1'b0, 1'b0);
			rx_send(20, 1'b1, 1'b0);
			rx_send(106, 1'b1, 1'b1);
			send_cells(2);
			wait_empty();
		end
		$display("test atm_traffic done");
		queue_add_set <= 1'b1;
		@(posedge clock);
		queue_add_set <= 1'b0;
		repeat (3) @(posedge clock);
		`CHK("attention", 1'b0, queue_add_attention)
		hold <= 1'b1;
		rx_send(159, 1'b1, 1'b1);
		repeat (600) @(posedge clock);
		`CHK("rx_ren_n", 1'b1, atm_rx_read_enable_n)
		hold <= 1'b0;
		wait_empty();
		$display("test rx_stall done");
		do_reset(1'b1);
		send_cells(2);
		wait_empty();
		cfg_single_phy <= 1'b1;
		cfg_write <= 1'b1;
		@(posedge clock);
		cfg_write <= 1'b0;
		send_cells(2);
		wait_empty();
		$display("test phy_roles done");
		conclude();
	end
	// Watchdog sized well past the expected run length.
	initial begin
		repeat (40000) @(posedge clock);
		failures++;
		conclude();
	end
endmodule // utopia_cell_port_tb
bind utopia_cell_port utopia_cell_port_sva chk (.*);

// ### bench/utopia_partner.sv
// Far-side model of the UTOPIA link: full, read and write enables, selects and a cell sender.
module utopia_partner (
	// Clocks and pacing
	input wire logic  tx_link_clock,
	input wire logic  rx_link_clock,
	input wire logic  slow,
	// Transmit link
	output logic      atm_tx_full_n,
	output logic      phy_tx_read_enable_n,
	output logic      phy_tx_select_n,
	// Receive link
	input wire logic  atm_rx_read_enable_n,
	output logic [7:0] rx_data_bus,
	output logic      rx_cell_start,
	output logic      atm_rx_empty_n,
	output logic      phy_rx_write_enable_n,
	output logic      phy_rx_select_n
);
	timeunit 1ns;
	timeprecision 1ns;
	int         seed = 32'h36e7cb29;
	logic [8:0] q[$];
	logic       e;
	task automatic put(input logic [8:0] w);
		q.push_back(w);
	endtask
	initial begin
		{atm_tx_full_n, phy_tx_read_enable_n, phy_tx_select_n, atm_rx_empty_n} = 4'hf;
		{phy_rx_write_enable_n, phy_rx_select_n, rx_cell_start, rx_data_bus} = 11'h600;
	end
	// Full is withheld a cycle or so at a time; select only moves while read enable is idle.
	always @(posedge tx_link_clock) begin
		atm_tx_full_n <= !slow || ($random(seed) & 3) != 0;
		phy_tx_read_enable_n <= 1'($random(seed));
		if (phy_tx_read_enable_n)
			phy_tx_select_n <= 1'($random(seed));
	end
	// A word leaves when enable and empty both pass; idle data toggles so stale bytes never look valid.
	always @(posedge rx_link_clock) begin
		if (atm_rx_empty_n && !atm_rx_read_enable_n)
			q.delete(0);
		e = q.size() != 0 && (!slow || 1'($random(seed)));
		atm_rx_empty_n <= e;
		{rx_cell_start, rx_data_bus} <= e ? q[0] : ~{rx_cell_start, rx_data_bus};
		phy_rx_write_enable_n <= 1'($random(seed));
		if (phy_rx_write_enable_n)
			phy_rx_select_n <= 1'($random(seed));
	end
endmodule // utopia_partner

// ### hdl/bit_sync.sv
// Two-stage synchroniser for levels and gray-coded pointers.
module bit_sync #(
	parameter int W = 1
) (
	// Destination clock
	input  wire logic         clock,
	// Source level
	input  wire logic [W-1:0] async_in,
	// Synchronised level
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge clock) begin
		meta_q <= async_in;
		sync_q <= meta_q;
	end

	assign sync_out = sync_q;

endmodule // bit_sync

// ### hdl/cell_mem.sv
// Dual-clock cell memory with registered read data.
module cell_mem #(
	parameter int AW = 7,
	parameter int DW = 9
) (
	// Write side clock
	input  wire logic wr_clock,
	// Read side clock
	input  wire logic rd_clock,
	// Memory port
	cell_mem_if.mem   port
);

	logic [DW-1:0] store_q [0:(1 << AW) - 1];
	logic [DW-1:0] rd_data_q;

	// Write port; the pointer that announces a word crosses later than the word.
	always_ff @(posedge wr_clock) begin
		if (port.wr_en) begin
			store_q[port.wr_addr] <= port.wr_data;
		end
	end

	// Read port; the address is re-read every edge, so stale data cannot linger.
	always_ff @(posedge rd_clock) begin
		rd_data_q <= store_q[port.rd_addr];
	end

	assign port.rd_data = rd_data_q;

endmodule // cell_mem

// ### hdl/utopia_cell_port.sv
// UTOPIA cell port: transmit and receive cell paths with their link logic.
//
// Contract
// [RQ1] Side pin selects ATM or PHY role.
// [RQ2] Single-PHY bit resets to multi-PHY.
// [RQ3] ATM transmit: cell start on first byte.
// [RQ4] ATM transmit pauses two cycles after full.
// [RQ5] PHY transmit drives bus only when sending.
// [RQ6] Transmit cell-available enable follows delayed address.
// [RQ7] Cell-available holds until cell read out.
// [RQ8] Single-PHY: next byte after read enable cycle.
// [RQ9] Multi-PHY transmit only when address selected.
// [RQ10] Partner withholds acceptance only briefly.
// [RQ11] Builder writes bytes with marker, stalls full.
// [RQ12] Attention bit stays set while FIFO full.
// [RQ13] Transmit read pointer returns to system clock.
// [RQ14] Transmit starts only with whole cell queued.
// [RQ15] ATM receive: read enable active in reset.
// [RQ16] Read enable reopens only for whole cell.
// [RQ17] New cell start restarts count, drops old.
// [RQ18] Byte valid: enable active, empty inactive.
// [RQ19] Receive FIFO written on link clock; stops full.
// [RQ20] Receive cell-available enable follows delayed address.
// [RQ21] Receive cell-available tristated in reset; selection.
// [RQ22] Cell-available drops at four bytes room.
`include "utopia_defs.svh"

module utopia_cell_port #(
	parameter int AW = 7
) (
	// System clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// Configuration and status
	input  wire logic       side_select_pin,
	input  wire logic       cfg_write,
	input  wire logic       cfg_single_phy,
	input  wire logic       queue_add_set,
	output logic            queue_add_attention,
	// Transmit cell builder side
	input  wire logic [7:0] builder_data,
	input  wire logic       builder_soc,
	input  wire logic       builder_valid,
	output logic            builder_ready,
	// Receive cell processor side
	output logic [7:0]      proc_data,
	output logic            proc_soc,
	output logic            proc_valid,
	input  wire logic       proc_ready,
	// Transmit link
	input  wire logic       tx_link_clock,
	output logic [7:0]      tx_data_bus,
	output logic            tx_data_bus_oe,
	output logic            tx_cell_start,
	output logic            tx_cell_start_oe,
	output logic            atm_tx_write_enable_n,
	output logic            atm_tx_write_enable_oe,
	input  wire logic       phy_tx_read_enable_n,
	input  wire logic       atm_tx_full_n,
	output logic            phy_tx_cell_avail,
	output logic            phy_tx_cell_avail_oe,
	input  wire logic       phy_tx_select_n,
	// Receive link
	input  wire logic       rx_link_clock,
	input  wire logic [7:0] rx_data_bus,
	input  wire logic       rx_cell_start,
	output logic            atm_rx_read_enable_n,
	output logic            atm_rx_read_enable_oe,
	input  wire logic       phy_rx_write_enable_n,
	input  wire logic       atm_rx_empty_n,
	output logic            phy_rx_cell_avail,
	output logic            phy_rx_cell_avail_oe,
	input  wire logic       phy_rx_select_n
);

	// ------------------------------------------------------------------------
	// Sizes and helpers
	// ------------------------------------------------------------------------
	localparam int              PW       = AW + 1;
	localparam int              DEPTH    = 1 << AW;
	localparam logic [PW-1:0]   CELL_PW  = PW'(`CELL_BYTES);
	localparam logic [PW-1:0]   DEPTH_PW = PW'(DEPTH);
	localparam logic [PW-1:0]   ATM_LOW  = PW'(`RX_ATM_LOW_ROOM);
	localparam logic [PW-1:0]   PHY_LOW  = PW'(`RX_LOW_ROOM);
	localparam logic [5:0]      LAST_IDX = 6'(`CELL_BYTES - 1);

	function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [PW-1:0] from_gray(input logic [PW-1:0] g);
		logic [PW-1:0] b;
		b = g;
		for (int i = PW - 2; i >= 0; i--) begin
			b[i] = b[i + 1] ^ g[i];
		end
		return b;
	endfunction

	// ------------------------------------------------------------------------
	// Cell memories
	// ------------------------------------------------------------------------
	cell_mem_if #(.AW(AW), .DW(`WORD_BITS)) tx_mem ();
	cell_mem_if #(.AW(AW), .DW(`WORD_BITS)) rx_mem ();

	cell_mem #(.AW(AW), .DW(`WORD_BITS)) tx_store (
		.wr_clock (clock),
		.rd_clock (tx_link_clock),
		.port     (tx_mem)
	);

	cell_mem #(.AW(AW), .DW(`WORD_BITS)) rx_store (
		.wr_clock (rx_link_clock),
		.rd_clock (clock),
		.port     (rx_mem)
	);

	// ------------------------------------------------------------------------
	// System clock domain
	// ------------------------------------------------------------------------
	logic          single_phy_select_q;
	logic          attention_q;
	logic [PW-1:0] tx_wptr_q;
	logic [PW-1:0] tx_wgray_q;
	logic [PW-1:0] tx_rgray_s;
	logic          tx_ready_q;
	logic [PW-1:0] rx_rptr_q;
	logic [PW-1:0] rx_rgray_q;
	logic [PW-1:0] rx_cgray_s;
	logic [7:0]    proc_data_q;
	logic          proc_soc_q;
	logic          proc_valid_q;

	// Builder writes and the room left; ready is registered, so it looks one write ahead.
	wire           tx_push     = builder_valid && tx_ready_q;
	wire [PW-1:0]  tx_wptr_d   = tx_wptr_q + PW'(tx_push);
	wire [PW-1:0]  tx_used_sys = tx_wptr_d - from_gray(tx_rgray_s); // RQ13
	wire           tx_ready_d  = tx_used_sys < DEPTH_PW;
	wire           attention_d = queue_add_set || (attention_q && !tx_ready_q); // RQ12

	assign tx_mem.wr_en   = tx_push; // RQ11
	assign tx_mem.wr_addr = tx_wptr_q[AW-1:0];
	assign tx_mem.wr_data = {builder_soc, builder_data}; // RQ11

	// Receive FIFO drain towards the cell processor, with a prefetching read address.
	wire           rx_nonempty = from_gray(rx_cgray_s) != rx_rptr_q;
	wire           rx_pop      = rx_nonempty && (!proc_valid_q || proc_ready);
	wire [PW-1:0]  rx_rptr_d   = rx_rptr_q + PW'(rx_pop);

	assign rx_mem.rd_addr = rx_rptr_d[AW-1:0];

	// Configuration bit and attention flag; a new set wins over the clear.
	always_ff @(posedge clock) begin
		if (reset) begin
			single_phy_select_q <= 1'b0; // RQ2
			attention_q         <= 1'b0;
		end else begin
			if (cfg_write) begin
				single_phy_select_q <= cfg_single_phy;
			end
			attention_q <= attention_d;
		end
	end

	// Transmit write pointer and its gray copy for the link side.
	always_ff @(posedge clock) begin
		if (reset) begin
			tx_wptr_q  <= '0;
			tx_wgray_q <= '0;
			tx_ready_q <= 1'b0;
		end else begin
			tx_wptr_q  <= tx_wptr_d;
			tx_wgray_q <= to_gray(tx_wptr_d);
			tx_ready_q <= tx_ready_d; // RQ11
		end
	end

	// Receive read pointer and output register towards the cell processor.
	always_ff @(posedge clock) begin
		if (reset) begin
			rx_rptr_q    <= '0;
			rx_rgray_q   <= '0;
			proc_data_q  <= 8'h00;
			proc_soc_q   <= 1'b0;
			proc_valid_q <= 1'b0;
		end else begin
			rx_rptr_q  <= rx_rptr_d;
			rx_rgray_q <= to_gray(rx_rptr_d);
			if (rx_pop) begin
				proc_data_q  <= rx_mem.rd_data[7:0];
				proc_soc_q   <= rx_mem.rd_data[`SOC_BIT];
				proc_valid_q <= 1'b1;
			end else if (proc_ready) begin
				proc_valid_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Crossings
	// ------------------------------------------------------------------------
	logic [2:0]    tx_ctl_s;
	logic [2:0]    rx_ctl_s;
	logic [PW-1:0] tx_wgray_s;
	logic [PW-1:0] rx_rgray_s;
	logic [PW-1:0] tx_rgray_q;
	logic [PW-1:0] rx_cgray_q;

	bit_sync #(.W(3)) tx_ctl_sync (
		.clock    (tx_link_clock),
		.async_in ({reset, side_select_pin, single_phy_select_q}),
		.sync_out (tx_ctl_s)
	);
	bit_sync #(.W(3)) rx_ctl_sync (
		.clock    (rx_link_clock),
		.async_in ({reset, side_select_pin, single_phy_select_q}),
		.sync_out (rx_ctl_s)
	);
	bit_sync #(.W(PW)) tx_wptr_sync (.clock(tx_link_clock), .async_in(tx_wgray_q), .sync_out(tx_wgray_s));
	bit_sync #(.W(PW)) tx_rptr_sync (.clock(clock), .async_in(tx_rgray_q), .sync_out(tx_rgray_s));
	bit_sync #(.W(PW)) rx_rptr_sync (.clock(rx_link_clock), .async_in(rx_rgray_q), .sync_out(rx_rgray_s));
	bit_sync #(.W(PW)) rx_cptr_sync (.clock(clock), .async_in(rx_cgray_q), .sync_out(rx_cgray_s));

	// ------------------------------------------------------------------------
	// Transmit link domain
	// ------------------------------------------------------------------------
	logic [PW-1:0]                  tx_rptr_q;
	logic [5:0]                     tx_cnt_q;
	logic [`FULL_PAUSE_CYCLES-1:0]  tx_full_dly_q;
	logic                           tx_ren_prev_q;
	logic                           tx_sel_q;
	logic [7:0]                     tx_data_q;
	logic                           tx_soc_q;
	logic                           tx_drive_q;
	logic                           tx_wen_n_q;
	logic                           tx_wen_oe_q;
	logic                           tx_clav_q;
	logic                           tx_clav_oe_q;

	// Role and send decision; the full input runs through a two-stage delay line.
	wire                    tx_reset    = tx_ctl_s[2];
	utopia_pkg::link_mode_e tx_mode;
	assign tx_mode = utopia_pkg::mode_of(tx_ctl_s[1], tx_ctl_s[0]); // RQ1
	wire           tx_atm      = tx_mode == utopia_pkg::MODE_ATM;
	wire           tx_single   = tx_mode == utopia_pkg::MODE_PHY_SINGLE;
	wire [PW-1:0]  tx_used     = from_gray(tx_wgray_s) - tx_rptr_q;
	wire           tx_may_send = (tx_cnt_q != 6'h00) || (tx_used >= CELL_PW); // RQ14
	wire           tx_fall     = tx_ren_prev_q && !phy_tx_read_enable_n;
	wire           tx_sel      = tx_fall ? !phy_tx_select_n : tx_sel_q; // RQ9
	wire           tx_phy_go   = !phy_tx_read_enable_n && (tx_single || tx_sel); // RQ8
	wire           tx_atm_go   = tx_full_dly_q[`FULL_PAUSE_CYCLES-1]; // RQ4
	wire           tx_adv      = tx_may_send && (tx_atm ? tx_atm_go : tx_phy_go);
	wire           tx_last     = tx_cnt_q == LAST_IDX;
	wire [5:0]     tx_cnt_d    = tx_adv ? (tx_last ? 6'h00 : tx_cnt_q + 6'h01) : tx_cnt_q;
	wire [PW-1:0]  tx_rptr_d   = tx_rptr_q + PW'(tx_adv);
	wire           tx_clav_d   = (tx_cnt_d != 6'h00) || ((tx_used - PW'(tx_adv)) >= CELL_PW); // RQ7

	assign tx_mem.rd_addr = tx_rptr_d[AW-1:0];

	// Read pointer, byte counter and link input history.
	always_ff @(posedge tx_link_clock) begin
		if (tx_reset) begin
			tx_rptr_q     <= '0;
			tx_rgray_q    <= '0;
			tx_cnt_q      <= 6'h00;
			tx_full_dly_q <= '0;
			tx_ren_prev_q <= 1'b1;
			tx_sel_q      <= 1'b0;
		end else begin
			tx_rptr_q     <= tx_rptr_d;
			tx_rgray_q    <= to_gray(tx_rptr_d); // RQ13
			tx_cnt_q      <= tx_cnt_d;
			tx_full_dly_q <= {tx_full_dly_q[`FULL_PAUSE_CYCLES-2:0], atm_tx_full_n}; // RQ4
			tx_ren_prev_q <= phy_tx_read_enable_n;
			tx_sel_q      <= tx_sel;
		end
	end

	// Pin drivers; the ATM role holds the bus at all times, the PHY role only while sending.
	always_ff @(posedge tx_link_clock) begin
		if (tx_reset) begin
			tx_data_q    <= 8'h00;
			tx_soc_q     <= 1'b0;
			tx_drive_q   <= tx_atm;
			tx_wen_n_q   <= 1'b1;
			tx_wen_oe_q  <= tx_atm;
			tx_clav_q    <= 1'b0;
			tx_clav_oe_q <= 1'b0;
		end else begin
			if (tx_adv) begin
				tx_data_q <= tx_mem.rd_data[7:0];
			end
			tx_soc_q     <= tx_adv && tx_mem.rd_data[`SOC_BIT]; // RQ3
			tx_drive_q   <= tx_atm || tx_adv; // RQ3 RQ5
			tx_wen_n_q   <= !(tx_atm && tx_adv);
			tx_wen_oe_q  <= tx_atm; // RQ1
			tx_clav_q    <= tx_clav_d; // RQ7
			tx_clav_oe_q <= !tx_atm && (tx_single || !phy_tx_select_n); // RQ6
		end
	end

	// ------------------------------------------------------------------------
	// Receive link domain
	// ------------------------------------------------------------------------
	logic [PW-1:0]        rx_wptr_q;
	logic [PW-1:0]        rx_commit_q;
	logic [5:0]           rx_cnt_q;
	logic                 rx_wen_prev_q;
	logic                 rx_sel_q;
	logic                 rx_ren_n_q;
	logic                 rx_ren_oe_q;
	logic                 rx_clav_q;
	logic                 rx_clav_oe_q;
	utopia_pkg::rx_flow_e rx_flow_q;
	utopia_pkg::rx_flow_e rx_flow_d;

	// Byte acceptance; only the committed pointer is shown to the drain side,
	// so a cell cut short by a new start never reaches the processor.
	wire                    rx_reset   = rx_ctl_s[2];
	utopia_pkg::link_mode_e rx_mode;
	assign rx_mode = utopia_pkg::mode_of(rx_ctl_s[1], rx_ctl_s[0]); // RQ1
	wire           rx_atm      = rx_mode == utopia_pkg::MODE_ATM;
	wire           rx_single   = rx_mode == utopia_pkg::MODE_PHY_SINGLE;
	wire [PW-1:0]  rx_free     = DEPTH_PW - (rx_wptr_q - from_gray(rx_rgray_s));
	wire           rx_fall     = rx_wen_prev_q && !phy_rx_write_enable_n;
	wire           rx_sel      = rx_fall ? !phy_rx_select_n : rx_sel_q; // RQ21
	wire           rx_byte_atm = !rx_ren_n_q && atm_rx_empty_n; // RQ18
	wire           rx_byte_phy = !phy_rx_write_enable_n && (rx_single || rx_sel); // RQ21
	wire           rx_byte     = rx_atm ? rx_byte_atm : rx_byte_phy;
	wire           rx_in_cell  = rx_cell_start || (rx_cnt_q != 6'h00);
	wire           rx_keep     = rx_byte && rx_in_cell && (rx_free != '0); // RQ19
	wire           rx_drop     = rx_byte && rx_in_cell && (rx_free == '0);
	wire [PW-1:0]  rx_base     = rx_cell_start ? rx_commit_q : rx_wptr_q; // RQ17
	wire           rx_last     = !rx_cell_start && (rx_cnt_q == LAST_IDX);
	wire [PW-1:0]  rx_wptr_d   = rx_keep ? rx_base + PW'(1) : (rx_drop ? rx_commit_q : rx_wptr_q);
	wire [PW-1:0]  rx_commit_d = (rx_keep && rx_last) ? rx_base + PW'(1) : rx_commit_q;
	wire [5:0]     rx_cnt_keep = rx_cell_start ? 6'h01 : (rx_last ? 6'h00 : rx_cnt_q + 6'h01); // RQ17
	wire [5:0]     rx_cnt_d    = rx_keep ? rx_cnt_keep : (rx_drop ? 6'h00 : rx_cnt_q);
	wire [PW-1:0]  rx_room     = rx_free - PW'(rx_keep);
	wire [PW-1:0]  rx_low      = rx_atm ? ATM_LOW : PHY_LOW;
	wire           rx_open_d   = rx_flow_d == utopia_pkg::FLOW_OPEN;
	wire [PW-1:0]  rx_pub      = from_gray(rx_cgray_q); // A cell commit jumps 53; the crossing must step by one.

	assign rx_mem.wr_en   = rx_keep; // RQ19
	assign rx_mem.wr_addr = rx_base[AW-1:0];
	assign rx_mem.wr_data = {rx_cell_start, rx_data_bus};

	// Space hysteresis: close near full, reopen only when a whole cell fits.
	always_comb begin
		rx_flow_d = rx_flow_q;
		unique case (rx_flow_q)
			utopia_pkg::FLOW_OPEN: begin
				if (rx_room <= rx_low) begin
					rx_flow_d = utopia_pkg::FLOW_HELD; // RQ22
				end
			end
			utopia_pkg::FLOW_HELD: begin
				if (rx_room >= CELL_PW) begin
					rx_flow_d = utopia_pkg::FLOW_OPEN; // RQ16
				end
			end
		endcase
	end

	// Write pointers, byte counter and selection capture.
	always_ff @(posedge rx_link_clock) begin
		if (rx_reset) begin
			rx_wptr_q     <= '0;
			rx_commit_q   <= '0;
			rx_cgray_q    <= '0;
			rx_cnt_q      <= 6'h00;
			rx_wen_prev_q <= 1'b1;
			rx_sel_q      <= 1'b0;
			rx_flow_q     <= utopia_pkg::FLOW_OPEN;
		end else begin
			rx_wptr_q     <= rx_wptr_d;
			rx_commit_q   <= rx_commit_d;
			rx_cgray_q    <= to_gray(rx_pub + PW'(rx_pub != rx_commit_q));
			rx_cnt_q      <= rx_cnt_d;
			rx_wen_prev_q <= phy_rx_write_enable_n;
			rx_sel_q      <= rx_sel;
			rx_flow_q     <= rx_flow_d;
		end
	end

	// Pin drivers; the read enable depends on the space left after any byte accepted this cycle, which counts the empty input.
	always_ff @(posedge rx_link_clock) begin
		if (rx_reset) begin
			rx_ren_n_q   <= 1'b0; // RQ15
			rx_ren_oe_q  <= rx_atm;
			rx_clav_q    <= 1'b0;
			rx_clav_oe_q <= 1'b0; // RQ21
		end else begin
			rx_ren_n_q   <= !(rx_atm && rx_open_d); // RQ16
			rx_ren_oe_q  <= rx_atm;
			rx_clav_q    <= !rx_atm && rx_open_d; // RQ20 RQ22
			rx_clav_oe_q <= !rx_atm && (rx_single || !phy_rx_select_n); // RQ20
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign queue_add_attention    = attention_q;
	assign builder_ready          = tx_ready_q;
	assign proc_data              = proc_data_q;
	assign proc_soc               = proc_soc_q;
	assign proc_valid             = proc_valid_q;
	assign tx_data_bus            = tx_data_q;
	assign tx_data_bus_oe         = tx_drive_q;
	assign tx_cell_start          = tx_soc_q;
	assign tx_cell_start_oe       = tx_drive_q;
	assign atm_tx_write_enable_n  = tx_wen_n_q;
	assign atm_tx_write_enable_oe = tx_wen_oe_q;
	assign phy_tx_cell_avail      = tx_clav_q;
	assign phy_tx_cell_avail_oe   = tx_clav_oe_q;
	assign atm_rx_read_enable_n   = rx_ren_n_q;
	assign atm_rx_read_enable_oe  = rx_ren_oe_q;
	assign phy_rx_cell_avail      = rx_clav_q;
	assign phy_rx_cell_avail_oe   = rx_clav_oe_q;

endmodule // utopia_cell_port

// ### inc/cell_mem_if.sv
// Port bundle between the cell port and one of its cell memories.
interface cell_mem_if #(
	parameter int AW = 7,
	parameter int DW = 9
);
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;

	modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ### inc/utopia_defs.svh
// Shared constants of the UTOPIA cell port.
`ifndef UTOPIA_DEFS_SVH
`define UTOPIA_DEFS_SVH

// ----------------------------------------------------------------------------
// Cell framing
// ----------------------------------------------------------------------------
`define CELL_BYTES 53
`define SOC_BIT 8
`define WORD_BITS 9

// ----------------------------------------------------------------------------
// Flow control
// ----------------------------------------------------------------------------
`define FULL_PAUSE_CYCLES 2
`define RX_LOW_ROOM 4
`define RX_ATM_LOW_ROOM 1

`endif

// ### inc/utopia_pkg.sv
// Types shared by the UTOPIA cell port modules.
package utopia_pkg;

	// ------------------------------------------------------------------------
	// Role of the port on the link
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_ATM        = 2'b00,
		MODE_PHY_SINGLE = 2'b01,
		MODE_PHY_MULTI  = 2'b10
	} link_mode_e;

	// Receive acceptance state: open to the partner or held until a cell fits.
	typedef enum logic {
		FLOW_OPEN = 1'b0,
		FLOW_HELD = 1'b1
	} rx_flow_e;

	// Role decode from the side pin and the single-PHY configuration bit.
	function automatic link_mode_e mode_of(input logic phy_side, input logic single);
		if (!phy_side) begin
			return MODE_ATM;
		end
		return single ? MODE_PHY_SINGLE : MODE_PHY_MULTI;
	endfunction

endpackage
